// ==== pkg/cfdram_pkg.sv ====
package cfdram_pkg;

    // Fixed message RAM areas, byte addresses
    localparam logic [11:0] TXMB_BASE        = 12'h000;
    localparam int          TXMB_COUNT       = 4;
    localparam int          TXMB_BYTES       = 76;
    localparam logic [11:0] TXMB_AREA        = 12'(TXMB_COUNT * TXMB_BYTES);
    localparam int          THL_ENTRIES      = 8;
    localparam int          THL_ENTRY_BYTES  = 8;
    localparam logic [11:0] THL_AREA         = 12'(THL_ENTRIES * THL_ENTRY_BYTES);
    localparam int          OTB_COUNT        = 2;
    localparam int          OTB_BYTES        = 80;
    localparam logic [11:0] OTB_AREA         = 12'(OTB_COUNT * OTB_BYTES);
    localparam int          AFL_ENTRIES      = 16;
    localparam int          AFL_ENTRY_BYTES  = 16;
    localparam logic [11:0] AFL_AREA         = 12'(AFL_ENTRIES * AFL_ENTRY_BYTES);
    localparam int          PFL_ENTRIES      = 2;
    localparam int          PFL_ENTRY_BYTES  = 36;
    localparam logic [11:0] PFL_AREA         = 12'(PFL_ENTRIES * PFL_ENTRY_BYTES);
    localparam logic [11:0] THL_BASE         = TXMB_BASE + TXMB_AREA;
    localparam logic [11:0] OTB_BASE         = THL_BASE + THL_AREA;
    localparam logic [11:0] MB_BASE          = OTB_BASE + OTB_AREA;

    // Message pool limits
    localparam logic [11:0] MSG_HEADER_BYTES = 12'd12;
    localparam int          MAX_RX_MESSAGES  = 16;
    localparam int          MAX_SLOT_BYTES   = 76;
    localparam logic [11:0] MB_AREA_MAX      = 12'(MAX_RX_MESSAGES * MAX_SLOT_BYTES);
    localparam logic [11:0] MESSAGE_RAM_BYTES       = 12'd2072;

    // Test paging
    localparam int          PAGE_BYTES       = 256;
    localparam logic [3:0]  LAST_PAGE        = 4'h8;
    localparam logic [7:0]  LAST_PAGE_BYTES  = 8'd24;

    // Initialisation takes 520 cycles of the peripheral clock
    localparam logic [9:0]  INIT_CYCLES      = 10'd520;

    // Bit timing, example corner: 80 MHz bit clock
    localparam int          BIT_CLOCK_MHZ    = 80;
    localparam logic [7:0]  NOMINAL_TQ_1M    = 8'd80;
    localparam logic [7:0]  DATA_TQ_8M       = 8'd10;

    localparam logic [15:0] LOCK_KEY_FIRST   = 16'hC4F0;
    localparam logic [15:0] LOCK_KEY_SECOND  = 16'h0F4C;

    typedef enum logic [1:0] {
        cfdram_global_reset,
        cfdram_global_operation,
        cfdram_global_sleep,
        cfdram_global_halt
    } cfdram_global_mode_type;

    typedef struct packed {
        logic [2:0] depth;
        logic [2:0] payload;
        logic       enable;
    } cfdram_fifo_cfg_type;

    typedef struct packed {
        logic [5:0] count;
        logic [2:0] payload;
    } cfdram_rx_message_buffer_cfg_type;

    typedef struct packed {
        logic [11:0] rx_message_buffer_base;
        logic [11:0] rxfifo0_base;
        logic [11:0] rxfifo1_base;
        logic [11:0] common_fifo_base;
        logic [11:0] mb_end;
        logic        overflow;
    } cfdram_layout_type;

    function automatic logic [7:0] cfdram_payload_bytes(input logic [2:0] code);
        logic [7:0] bytes;
        bytes = 8'h00;
        unique case (code)
            3'h0: bytes = 8'd8;
            3'h1: bytes = 8'd12;
            3'h2: bytes = 8'd16;
            3'h3: bytes = 8'd20;
            3'h4: bytes = 8'd24;
            3'h5: bytes = 8'd32;
            3'h6: bytes = 8'd48;
            3'h7: bytes = 8'd64;
        endcase
        return bytes;
    endfunction

    function automatic logic [7:0] cfdram_depth_messages(input logic [2:0] code);
        logic [7:0] count;
        count = 8'h00;
        unique case (code)
            3'h0: count = 8'd0;
            3'h1: count = 8'd4;
            3'h2: count = 8'd8;
            3'h3: count = 8'd16;
            3'h4: count = 8'd32;
            3'h5: count = 8'd48;
            3'h6: count = 8'd64;
            3'h7: count = 8'd128;
        endcase
        return count;
    endfunction

endpackage

// ==== rtl/cfdram_layout.sv ====
`timescale 1ns/100ps
`default_nettype none

// Message buffer area layout from the receive configuration.
module cfdram_layout
    import cfdram_pkg::*;
(
    // Configuration
    input  wire cfdram_rx_message_buffer_cfg_type cfg_rx_message_buffer,
    input  wire cfdram_fifo_cfg_type cfg_rxfifo0,
    input  wire cfdram_fifo_cfg_type cfg_rxfifo1,
    input  wire cfdram_fifo_cfg_type cfg_common_fifo,
    // Result
    output var cfdram_layout_type    layout
);

    logic [17:0] rx_message_buffer_size;
    logic [17:0] rxf0_size;
    logic [17:0] rxf1_size;
    logic [17:0] cf_size;
    logic [17:0] total;

    function automatic logic [17:0] fifo_size(input cfdram_fifo_cfg_type f);
        logic [17:0] s;
        s = 18'h00000;
        if (f.enable)
            s = 18'(cfdram_depth_messages(f.depth))
              * 18'(MSG_HEADER_BYTES + 12'(cfdram_payload_bytes(f.payload)));
        return s;
    endfunction

    always_comb
    begin
        rx_message_buffer_size = 18'(cfg_rx_message_buffer.count)
                  * 18'(MSG_HEADER_BYTES + 12'(cfdram_payload_bytes(cfg_rx_message_buffer.payload)));
        rxf0_size = fifo_size(cfg_rxfifo0);
        rxf1_size = fifo_size(cfg_rxfifo1);
        cf_size   = fifo_size(cfg_common_fifo);
        total     = rx_message_buffer_size + rxf0_size + rxf1_size + cf_size;
        layout.rx_message_buffer_base    = MB_BASE;
        layout.rxfifo0_base = 12'(18'(MB_BASE) + rx_message_buffer_size);
        layout.rxfifo1_base = 12'(18'(MB_BASE) + rx_message_buffer_size + rxf0_size);
        layout.common_fifo_base   = 12'(18'(MB_BASE) + rx_message_buffer_size + rxf0_size + rxf1_size);
        layout.mb_end       = 12'(18'(MB_BASE) + total);
        layout.overflow     = total > 18'(MB_AREA_MAX);
    end

endmodule

`default_nettype wire

// ==== rtl/cfdram_top.sv ====
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Bit rate is bit clock over prescaler times quanta per bit.
// - 80 MHz, prescaler 1: 80 quanta gives 1 Mbps, 10 gives 8 Mbps.
// - Transmit buffers at 0x000, then history, then overflow buffers, no gaps.
// - Transmit buffer area is four buffers of 76 bytes, 304 bytes.
// - History area is eight entries of eight bytes, 64 bytes.
// - Overflow area is two 80 byte buffers right after history.
// - Acceptance filter table is 16 entries of 16 bytes.
// - Secondary filter table is two entries of 36 bytes.
// - Message buffer area follows overflow area, sized by receive configuration.
// - Order inside it: receive buffers, receive FIFOs, common FIFO.
// - Receive buffer region is count times header plus payload.
// - Receive FIFO region sums depth times header plus payload per FIFO.
// - Common FIFO region is depth times header plus payload.
// - Depth and payload codes are decoded to counts and bytes first.
// - CPU reaches the overflow area only in RAM test mode.
// - Full 2072 byte RAM initialises in 520 peripheral clock cycles.
// - After reset the controller sits in module stop, disabled.
// - Registers open only once module stop is released.
// - First key write ignored in global sleep or reset mode; the second key is taken in any mode.
module cfdram_top
    import cfdram_pkg::*;
#(
    parameter int PRESCALER_WIDTH = 10,
    parameter int TQ_WIDTH        = 8
)
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // Module stop
    input  wire logic                       module_stop_control_c,
    output logic                            regs_accessible,
    // Global mode and test
    input  wire cfdram_global_mode_type     global_mode,
    input  wire logic                       lock_key_write,
    input  wire logic [15:0]                lock_key_data,
    output logic [15:0]                     lock_key_read,
    input  wire logic                       ram_test_request,
    output logic                            ram_test_mode,
    input  wire logic [3:0]                 ram_test_page_select,
    // Bit timing
    input  wire logic [PRESCALER_WIDTH-1:0] prescaler_value,
    input  wire logic [TQ_WIDTH-1:0]        tq_per_bit,
    output logic                            tq_tick,
    output logic                            bit_tick,
    // Receive configuration
    input  wire cfdram_rx_message_buffer_cfg_type        rx_buffer_number_config,
    input  wire cfdram_fifo_cfg_type        rx_fifo_config_0,
    input  wire cfdram_fifo_cfg_type        rx_fifo_config_1,
    input  wire cfdram_fifo_cfg_type        common_fifo_config,
    output var cfdram_layout_type           layout,
    // CPU access to the message RAM
    input  wire logic                       cpu_req,
    input  wire logic                       cpu_write,
    input  wire logic [11:0]                cpu_addr,
    input  wire logic [7:0]                 cpu_wdata,
    output logic                            cpu_ack,
    output logic                            cpu_error,
    output logic [7:0]                      cpu_rdata,
    output logic                            init_busy
);

    logic                       running;
    logic [9:0]                 init_count;
    logic                       key_armed;
    logic [PRESCALER_WIDTH-1:0] presc_count;
    logic [TQ_WIDTH-1:0]        tq_count;
    logic [11:0]                phys_addr;
    logic                       in_otb;
    logic                       addr_ok;
    logic                       access_ok;
    logic [7:0]                 message_ram [0:2071];
    logic [11:0]                wipe_addr;
    logic [9:0]                 busy_span;

    cfdram_layout u_layout
    (
        .cfg_rx_message_buffer    (rx_buffer_number_config),
        .cfg_rxfifo0 (rx_fifo_config_0),
        .cfg_rxfifo1 (rx_fifo_config_1),
        .cfg_common_fifo   (common_fifo_config),
        .layout      (layout)
    );

    // Module stop: high input means stopped
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            running <= 1'b0;
        else
            running <= !module_stop_control_c;
    end

    assign regs_accessible = running && !init_busy;

    // Init walks four bytes a cycle over the whole RAM
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            init_count <= INIT_CYCLES;
        else if (!running)
            init_count <= INIT_CYCLES;
        else if (init_count != 10'd0)
            init_count <= init_count - 10'd1;
    end

    assign init_busy = init_count != 10'd0;
    assign wipe_addr = {INIT_CYCLES - init_count, 2'b00};

    // Busy length for the init check; a 520 cycle delay is too slow to unroll
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            busy_span <= 10'd0;
        else if (!running)
            busy_span <= 10'd0;
        else if (init_busy)
            busy_span <= busy_span + 10'd1;
    end

    // Two key writes in order arm the test mode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            key_armed <= 1'b0;
        else if (lock_key_write && regs_accessible
                 && global_mode != cfdram_global_sleep
                 && global_mode != cfdram_global_reset)
            key_armed <= lock_key_data == LOCK_KEY_FIRST;
        else if (ram_test_request)
            key_armed <= 1'b0;
    end

    assign lock_key_read = 16'h0000;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ram_test_mode <= 1'b0;
        else if (!running)
            ram_test_mode <= 1'b0;
        else if (ram_test_request)
            ram_test_mode <= key_armed && lock_key_write
                             && lock_key_data == LOCK_KEY_SECOND;
    end

    // Quantum and bit enables; zero prescaler field divides by one
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            presc_count <= '0;
            tq_count    <= '0;
        end
        else if (!running)
        begin
            presc_count <= '0;
            tq_count    <= '0;
        end
        else if (presc_count + 1'b1 >= prescaler_value)
        begin
            presc_count <= '0;
            if (tq_count + 1'b1 >= tq_per_bit)
                tq_count <= '0;
            else
                tq_count <= tq_count + 1'b1;
        end
        else
            presc_count <= presc_count + 1'b1;
    end

    assign tq_tick  = running && (presc_count + 1'b1 >= prescaler_value);
    assign bit_tick = tq_tick && (tq_count + 1'b1 >= tq_per_bit);

    // In test mode the address is a page offset; else direct
    always_comb
    begin
        phys_addr = cpu_addr;
        // Pool, then secondary and acceptance tables close the RAM
        addr_ok   = cpu_addr < MB_BASE + MB_AREA_MAX + PFL_AREA + AFL_AREA;
        if (ram_test_mode)
        begin
            phys_addr = {ram_test_page_select, cpu_addr[7:0]};
            addr_ok   = ram_test_page_select < LAST_PAGE
                     || (ram_test_page_select == LAST_PAGE
                         && cpu_addr[7:0] < LAST_PAGE_BYTES);
        end
    end

    assign in_otb    = phys_addr >= OTB_BASE && phys_addr < MB_BASE;
    assign access_ok = regs_accessible && addr_ok
                       && (!in_otb || ram_test_mode);

    always_ff @(posedge clk)
    begin
        if (init_busy && running)
        begin
            for (int i = 0; i < 4; i++)
                if (32'(wipe_addr) + 32'(i) < 32'(MESSAGE_RAM_BYTES))
                    message_ram[32'(wipe_addr) + 32'(i)] <= 8'h00;
        end
        else if (cpu_req && cpu_write && access_ok)
            message_ram[phys_addr] <= cpu_wdata;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cpu_ack   <= 1'b0;
            cpu_error <= 1'b0;
            cpu_rdata <= 8'h00;
        end
        else
        begin
            cpu_ack   <= cpu_req;
            cpu_error <= cpu_req && !access_ok;
            cpu_rdata <= (cpu_req && !cpu_write && access_ok) ? message_ram[phys_addr] : 8'h00;
        end
    end

    chk_stop_after_reset: assert property (@(posedge clk) $rose(rstn) |-> !regs_accessible)
        else $error("registers open straight after reset");
    chk_init_length: assert property (@(posedge clk) disable iff (!rstn)
        running && $fell(init_busy) |-> busy_span == INIT_CYCLES)
        else $error("init did not take 520 cycles");
    chk_init_bound: assert property (@(posedge clk) disable iff (!rstn)
        init_busy |-> busy_span < INIT_CYCLES)
        else $error("init ran past 520 cycles");
    chk_refuse_busy: assert property (@(posedge clk) disable iff (!rstn)
        cpu_req && init_busy |=> cpu_error)
        else $error("access taken during init");
    chk_otb_guard: assert property (@(posedge clk) disable iff (!rstn)
        cpu_req && !ram_test_mode && cpu_addr >= OTB_BASE && cpu_addr < MB_BASE |=> cpu_error)
        else $error("overflow area reached outside test");
    chk_key_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
        lock_key_read == 16'h0000)
        else $error("lock key read nonzero");
    chk_key_sleep_ignored: assert property (@(posedge clk) disable iff (!rstn)
        lock_key_write && !ram_test_request
        && (global_mode == cfdram_global_sleep || global_mode == cfdram_global_reset)
        |=> $stable(key_armed))
        else $error("key taken in sleep");
    chk_last_page_limit: assert property (@(posedge clk) disable iff (!rstn)
        cpu_req && ram_test_mode && ram_test_page_select == LAST_PAGE
        && cpu_addr[7:0] >= LAST_PAGE_BYTES |=> cpu_error)
        else $error("beyond last page limit");
    chk_area_order: assert property (@(posedge clk)
        layout.rx_message_buffer_base == 12'h210 && layout.rxfifo0_base >= layout.rx_message_buffer_base
        && layout.rxfifo1_base >= layout.rxfifo0_base
        && layout.common_fifo_base >= layout.rxfifo1_base
        && layout.mb_end >= layout.common_fifo_base)
        else $error("message area order broken");
    chk_bit_period: assert property (@(posedge clk) disable iff (!rstn)
        bit_tick && prescaler_value == 1 && tq_per_bit == 10 && $stable(tq_per_bit)
        |-> ##10 (bit_tick || prescaler_value != 1 || tq_per_bit != 10))
        else $error("bit period not ten quanta");

endmodule

`default_nettype wire

// ==== tb/cfdram_bit_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none

// Far-side bus node: measures the bit period it is clocked with
module cfdram_bit_monitor
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Bit timing from the controller
    input  wire logic        bit_tick,
    // Cycles between the last two bit boundaries
    output logic [15:0]      bit_period
);
    logic [15:0] cycle_count;

    // Counter may wrap while stopped; only the period after a tick is used
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cycle_count <= 16'h0000;
            bit_period  <= 16'h0000;
        end
        else if (bit_tick)
        begin
            cycle_count <= 16'h0000;
            bit_period  <= cycle_count + 16'h0001;
        end
        else
        begin
            cycle_count <= cycle_count + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// ==== tb/cfdram_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module cfdram_top_tb
    import cfdram_pkg::*;
;
    logic                   clk = 1'b0;
    logic                   rstn = 1'b0;
    logic                   module_stop_control_c = 1'b1;
    logic                   regs_accessible;
    cfdram_global_mode_type global_mode = cfdram_global_sleep;
    logic                   lock_key_write = 1'b0;
    logic [15:0]            lock_key_data = 16'h0000;
    logic [15:0]            lock_key_read;
    logic                   ram_test_request = 1'b0;
    logic                   ram_test_mode;
    logic [3:0]             ram_test_page_select = 4'h0;
    logic [9:0]             prescaler_value = 10'h001;
    logic [7:0]             tq_per_bit = 8'h50;
    logic                   tq_tick;
    logic                   bit_tick;
    cfdram_rx_message_buffer_cfg_type    rx_buffer_number_config = '0;
    cfdram_fifo_cfg_type    rx_fifo_config_0 = '0;
    cfdram_fifo_cfg_type    rx_fifo_config_1 = '0;
    cfdram_fifo_cfg_type    common_fifo_config = '0;
    cfdram_layout_type      layout;
    logic                   cpu_req = 1'b0;
    logic                   cpu_write = 1'b0;
    logic [11:0]            cpu_addr = 12'h000;
    logic [7:0]             cpu_wdata = 8'h00;
    logic                   cpu_ack;
    logic                   cpu_error;
    logic [7:0]             cpu_rdata;
    logic                   init_busy;
    logic [15:0]            bit_period;
    int                     num_errors = 0;
    int                     n_tests = 0;
    int                     cycles = 0;
    int                     n;

    cfdram_top uut (.clk(clk), .rstn(rstn), .module_stop_control_c(module_stop_control_c),
        .regs_accessible(regs_accessible), .global_mode(global_mode),
        .lock_key_write(lock_key_write), .lock_key_data(lock_key_data),
        .lock_key_read(lock_key_read), .ram_test_request(ram_test_request),
        .ram_test_mode(ram_test_mode), .ram_test_page_select(ram_test_page_select),
        .prescaler_value(prescaler_value), .tq_per_bit(tq_per_bit), .tq_tick(tq_tick),
        .bit_tick(bit_tick), .rx_buffer_number_config(rx_buffer_number_config),
        .rx_fifo_config_0(rx_fifo_config_0), .rx_fifo_config_1(rx_fifo_config_1),
        .common_fifo_config(common_fifo_config), .layout(layout), .cpu_req(cpu_req),
        .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_ack(cpu_ack), .cpu_error(cpu_error), .cpu_rdata(cpu_rdata),
        .init_busy(init_busy));

    cfdram_bit_monitor node (.clk(clk), .rstn(rstn), .bit_tick(bit_tick),
        .bit_period(bit_period));

    always #5 clk = ~clk;

    task automatic finish_test();
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Run is under a thousand cycles; this ceiling only catches a hang
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One byte access; read data is checked on every read and is zero when refused
    task automatic cpu(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic exp_err, input logic [7:0] exp_rd);
        cpu_req = 1'b1;
        cpu_write = wr;
        cpu_addr = a;
        cpu_wdata = d;
        @(posedge clk);
        #1;
        cpu_req = 1'b0;
        check("cpu_ack", 16'(cpu_ack), 16'h0001);
        check("cpu_error", 16'(cpu_error), 16'(exp_err));
        if (!wr)
            check("cpu_rdata", 16'(cpu_rdata), 16'(exp_rd));
        @(posedge clk);
        #1;
    endtask

    task automatic key(input logic [15:0] v, input logic req);
        lock_key_write = 1'b1;
        lock_key_data = v;
        ram_test_request = req;
        @(posedge clk);
        #1;
        lock_key_write = 1'b0;
        ram_test_request = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic check_layout(input logic [11:0] rb, input logic [11:0] f0,
                                input logic [11:0] f1, input logic [11:0] cf,
                                input logic [11:0] e, input logic ovf);
        @(posedge clk);
        #1;
        check("rx_message_buffer_base", 16'(layout.rx_message_buffer_base), 16'(rb));
        check("rxfifo0_base", 16'(layout.rxfifo0_base), 16'(f0));
        check("rxfifo1_base", 16'(layout.rxfifo1_base), 16'(f1));
        check("common_fifo_base", 16'(layout.common_fifo_base), 16'(cf));
        check("mb_end", 16'(layout.mb_end), 16'(e));
        check("overflow", 16'(layout.overflow), 16'(ovf));
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        check("regs_accessible", 16'(regs_accessible), 16'h0000);
        check("init_busy", 16'(init_busy), 16'h0001);
        check("ram_test_mode", 16'(ram_test_mode), 16'h0000);
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        cpu(1'b0, 12'h210, 8'h00, 1'b1, 8'h00);
        check("regs_accessible", 16'(regs_accessible), 16'h0000);
        module_stop_control_c = 1'b0;
        cpu(1'b0, 12'h210, 8'h00, 1'b1, 8'h00);
        cpu(1'b0, 12'h210, 8'h00, 1'b1, 8'h00);
        // Four busy cycles have passed in the two calls above
        n = 4;
        while (init_busy === 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            if (init_busy === 1'b1)
                n++;
        end
        check("init_cycles", 16'(n), 16'd520);
        check("regs_accessible", 16'(regs_accessible), 16'h0001);
        // Example pool: 4 buffers, FIFOs of 16, 8 and 4 messages
        rx_buffer_number_config = '{count: 6'd4, payload: 3'h3};
        rx_fifo_config_0 = '{depth: 3'h3, payload: 3'h5, enable: 1'b1};
        rx_fifo_config_1 = '{depth: 3'h2, payload: 3'h0, enable: 1'b1};
        common_fifo_config = '{depth: 3'h1, payload: 3'h0, enable: 1'b1};
        check_layout(12'h210, 12'h290, 12'h550, 12'h5F0, 12'h640, 1'b0);
        // Sixteen full slots fill the pool exactly
        rx_buffer_number_config = '{count: 6'd16, payload: 3'h7};
        rx_fifo_config_0 = '0;
        rx_fifo_config_1 = '0;
        common_fifo_config = '0;
        check_layout(12'h210, 12'h6D0, 12'h6D0, 12'h6D0, 12'h6D0, 1'b0);
        common_fifo_config = '{depth: 3'h1, payload: 3'h0, enable: 1'b1};
        check_layout(12'h210, 12'h6D0, 12'h6D0, 12'h6D0, 12'h720, 1'b1);
        rx_fifo_config_0 = '{depth: 3'h1, payload: 3'h7, enable: 1'b1};
        rx_buffer_number_config = '{count: 6'd0, payload: 3'h0};
        check_layout(12'h210, 12'h210, 12'h340, 12'h340, 12'h390, 1'b0);
        cpu(1'b1, 12'h210, 8'hA5, 1'b0, 8'h00);
        cpu(1'b0, 12'h210, 8'h00, 1'b0, 8'hA5);
        cpu(1'b1, 12'h16F, 8'h3C, 1'b0, 8'h00);
        cpu(1'b0, 12'h16F, 8'h00, 1'b0, 8'h3C);
        cpu(1'b0, 12'h170, 8'h00, 1'b1, 8'h00);
        cpu(1'b0, 12'h20F, 8'h00, 1'b1, 8'h00);
        cpu(1'b0, 12'h817, 8'h00, 1'b0, 8'h00);
        cpu(1'b0, 12'h818, 8'h00, 1'b1, 8'h00);
        // Key sequence while asleep or in global reset must be ignored
        key(LOCK_KEY_FIRST, 1'b0);
        key(LOCK_KEY_SECOND, 1'b1);
        check("ram_test_mode", 16'(ram_test_mode), 16'h0000);
        global_mode = cfdram_global_reset;
        key(LOCK_KEY_FIRST, 1'b0);
        key(LOCK_KEY_SECOND, 1'b1);
        check("ram_test_mode", 16'(ram_test_mode), 16'h0000);
        global_mode = cfdram_global_operation;
        key(LOCK_KEY_FIRST, 1'b0);
        check("lock_key_read", lock_key_read, 16'h0000);
        key(LOCK_KEY_SECOND, 1'b1);
        check("ram_test_mode", 16'(ram_test_mode), 16'h0001);
        ram_test_page_select = 4'h2;
        cpu(1'b0, 12'h010, 8'h00, 1'b0, 8'hA5);
        ram_test_page_select = 4'h1;
        cpu(1'b1, 12'h070, 8'h5A, 1'b0, 8'h00);
        cpu(1'b0, 12'h070, 8'h00, 1'b0, 8'h5A);
        ram_test_page_select = 4'h8;
        cpu(1'b0, 12'h017, 8'h00, 1'b0, 8'h00);
        cpu(1'b0, 12'h018, 8'h00, 1'b1, 8'h00);
        ram_test_page_select = 4'h9;
        cpu(1'b0, 12'h000, 8'h00, 1'b1, 8'h00);
        key(16'h0000, 1'b1);
        check("ram_test_mode", 16'(ram_test_mode), 16'h0000);
        cpu(1'b0, 12'h170, 8'h00, 1'b1, 8'h00);
        // Bit rates: 1 Mbps and 8 Mbps corners, then an odd divider pair
        repeat (200) @(posedge clk);
        #1;
        check("bit_period_80", bit_period, 16'd80);
        tq_per_bit = 8'h0A;
        repeat (40) @(posedge clk);
        #1;
        check("bit_period_10", bit_period, 16'd10);
        prescaler_value = 10'h003;
        tq_per_bit = 8'h07;
        repeat (80) @(posedge clk);
        #1;
        check("bit_period_21", bit_period, 16'd21);
        n = 0;
        repeat (30)
        begin
            @(posedge clk);
            #1;
            if (tq_tick === 1'b1)
                n++;
        end
        check("tq_ticks", 16'(n), 16'd10);
        finish_test();
    end
endmodule

`default_nettype wire
